// ===== hdl/cssi_top.sv
// Program counter, return stack, status word and interrupt entry
`timescale 1ns/1ns
`include "cssi_defines.svh"
module cssi_top (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESET_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Pins
   input wire logic INT_N,
   input wire logic TEST_INPUT_A,
   input wire logic TEST_INPUT_B,
   // Core side
   output logic [11:0] PC_OUT,
   output logic [7:0] PROGRAM_STATUS,
   output logic REG_BANK_SELECT,
   output logic IRQ_ACTIVE
);
   logic rst_s1_reg, rst_n;
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // Bus decode
   wire bus_wr = PSEL && PENABLE && PWRITE;
   wire bus_rd_phase = PSEL && PENABLE && !PWRITE;
   wire hit_pc = (PADDR == `CSSI_ADDR_PC);
   wire hit_status = (PADDR == `CSSI_ADDR_STATUS);
   wire hit_cmd = (PADDR == `CSSI_ADDR_CMD);
   wire hit_stat = (PADDR == `CSSI_ADDR_STAT);
   wire hit_cond = (PADDR == `CSSI_ADDR_COND);
   wire hit_ram = (PADDR[11:7] == 5'h02) && (PADDR[1:0] == 2'b00);
   wire mapped = hit_pc | hit_status | hit_cmd | hit_stat | hit_cond | hit_ram;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;

   // Command word: op, carry/half-carry fields, timer request, call target
   wire cmd_go = bus_wr && hit_cmd;
   wire [3:0] cmd_op = PWDATA[3:0];
   wire cmd_set_carry = PWDATA[4];
   wire cmd_carry = PWDATA[5];
   wire cmd_set_half = PWDATA[6];
   wire cmd_half = PWDATA[7];
   wire cmd_tmr_edge = PWDATA[8];

   cssi_pkg::cssi_state_t state_reg, state_next;
   logic [11:0] pc_reg, pc_next, target_reg;
   logic [2:0] sp_reg;
   logic [3:0] status_hi_reg;
   logic bank_reg, irq_en_reg, tmr_en_reg, in_irq_reg, tmr_pend_reg, tmr_ovf_reg;
   logic cnt_mode_reg, second_cyc_reg, prev_tb_reg;
   logic [7:0] count_reg, cond_sel_reg;
   logic [7:0] acc_reg;
   logic cond_taken;

   wire [7:0] status_word = {status_hi_reg, 1'b1, sp_reg};
   // Three-bit pointer arithmetic gives both stack wraps with no extra logic
   wire [2:0] sp_dec = sp_reg - 3'h1;
   wire [2:0] sp_inc = sp_reg + 3'h1;

   function automatic [4:0] stack_addr(input logic [2:0] sp, input logic odd);
      logic [7:0] a;
      a = `CSSI_STACK_BASE + {4'h0, sp, 1'b0} + {7'h00, odd};
      stack_addr = a[4:0];
   endfunction

   // Instruction step: a one-cycle op samples now; two-cycle samples on its second
   wire op_step = cmd_go && (cmd_op == cssi_pkg::OP_STEP);
   wire op_step2 = cmd_go && (cmd_op == cssi_pkg::OP_STEP2);
   wire sample_now = (op_step && !second_cyc_reg) || (op_step2 && second_cyc_reg);
   wire ext_req = !INT_N && irq_en_reg;
   wire tmr_req = tmr_pend_reg && tmr_en_reg;
   wire can_take = !in_irq_reg && (state_reg == cssi_pkg::ST_IDLE);
   wire take_ext = sample_now && can_take && ext_req;
   wire take_tmr = sample_now && can_take && !ext_req && tmr_req;
   wire do_call = cmd_go && (cmd_op == cssi_pkg::OP_CALL) && (state_reg == cssi_pkg::ST_IDLE);
   wire do_ret = cmd_go && (state_reg == cssi_pkg::ST_IDLE) &&
      ((cmd_op == cssi_pkg::OP_RETURN_PLAIN) || (cmd_op == cssi_pkg::OP_RETURN_RESTORE));
   wire restore = cmd_op == cssi_pkg::OP_RETURN_RESTORE;
   logic restore_reg;

   // Counter overflow in event mode on falling edge of test input b
   wire tb_fall = prev_tb_reg && !TEST_INPUT_B;
   wire cnt_ovf = cnt_mode_reg && tb_fall && (count_reg == `CSSI_CNT_TOP);

   // RAM traffic
   logic ram_we;
   logic [4:0] ram_waddr, ram_raddr_a;
   logic [7:0] ram_wdata, ram_rd_a, ram_rd_b;
   wire ram_bus_wr = bus_wr && hit_ram && (state_reg == cssi_pkg::ST_IDLE);
   always_comb begin
      ram_we = 1'b0;
      ram_waddr = PADDR[6:2];
      ram_wdata = PWDATA[7:0];
      if (state_reg == cssi_pkg::ST_PUSH_LO) begin
         ram_we = 1'b1;
         ram_waddr = stack_addr(sp_reg, 1'b0);
         ram_wdata = pc_reg[7:0];
      end else if (state_reg == cssi_pkg::ST_PUSH_HI) begin
         ram_we = 1'b1;
         ram_waddr = stack_addr(sp_reg, 1'b1);
         ram_wdata = {status_hi_reg, pc_reg[11:8]};
      end else if (ram_bus_wr) begin
         ram_we = 1'b1;
      end
   end
   assign ram_raddr_a = (state_reg == cssi_pkg::ST_POP) ? stack_addr(sp_reg, 1'b0) : PADDR[6:2];

   cssi_stack_ram u_ram (
      .clk(CLOCK),
      .we(ram_we),
      .waddr(ram_waddr),
      .wdata(ram_wdata),
      .raddr_a(ram_raddr_a),
      .rdata_a(ram_rd_a),
      .raddr_b(stack_addr(sp_reg, 1'b1)),
      .rdata_b(ram_rd_b)
   );

   cssi_cond u_cond (
      .sel(cond_sel_reg[3:0]),
      .bit_sel(cond_sel_reg[6:4]),
      .acc(acc_reg),
      .carry(status_hi_reg[3]),
      .flag_a(status_hi_reg[1]),
      .flag_b(cond_sel_reg[7]),
      .tmr_ovf(tmr_ovf_reg),
      .test_a(TEST_INPUT_A),
      .test_b(TEST_INPUT_B),
      .int_n(INT_N),
      .taken(cond_taken)
   );

   // Sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         cssi_pkg::ST_IDLE: begin
            if (do_call || take_ext || take_tmr) state_next = cssi_pkg::ST_PUSH_LO;
            else if (do_ret) state_next = cssi_pkg::ST_POP;
         end
         cssi_pkg::ST_PUSH_LO: state_next = cssi_pkg::ST_PUSH_HI;
         cssi_pkg::ST_PUSH_HI: state_next = cssi_pkg::ST_IDLE;
         cssi_pkg::ST_POP: state_next = cssi_pkg::ST_IDLE;
         default: state_next = cssi_pkg::ST_IDLE;
      endcase
   end

   always_comb begin
      pc_next = pc_reg;
      if (state_reg == cssi_pkg::ST_PUSH_HI) pc_next = target_reg;
      else if (state_reg == cssi_pkg::ST_POP) pc_next = {ram_rd_b[3:0], ram_rd_a};
      else if (bus_wr && hit_pc && state_reg == cssi_pkg::ST_IDLE) pc_next = PWDATA[11:0];
      else if (sample_now || op_step2) pc_next = pc_reg + 12'h001;
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= cssi_pkg::ST_IDLE;
         pc_reg <= `CSSI_PC_RESET;
         target_reg <= `CSSI_PC_RESET;
         restore_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pc_reg <= pc_next;
         restore_reg <= (state_reg == cssi_pkg::ST_IDLE) ? restore : restore_reg;
         if (take_ext) target_reg <= `CSSI_VEC_EXT;
         else if (take_tmr) target_reg <= `CSSI_VEC_TMR;
         else if (do_call) target_reg <= PWDATA[27:16];
      end
   end

   // Stack pointer and status word
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         sp_reg <= 3'h0;
         status_hi_reg <= 4'h0;
      end else if (state_reg == cssi_pkg::ST_PUSH_HI) begin
         sp_reg <= sp_inc;
      end else if (state_reg == cssi_pkg::ST_POP) begin
         if (restore_reg) status_hi_reg <= ram_rd_b[7:4];
      end else if (do_ret) begin
         sp_reg <= sp_dec;
      end else if (bus_wr && hit_status) begin
         sp_reg <= PWDATA[2:0];
         status_hi_reg <= PWDATA[7:4];
      end else if (cmd_go) begin
         if (cmd_set_carry) status_hi_reg[3] <= cmd_carry;
         if (cmd_set_half) status_hi_reg[2] <= cmd_half;
         if (cmd_op == cssi_pkg::OP_CPL_FLAG) status_hi_reg[1] <= ~status_hi_reg[1];
         if (cmd_op == cssi_pkg::OP_CLR_FLAG) status_hi_reg[1] <= 1'b0;
         if (cmd_op == cssi_pkg::OP_SEL_RB0) status_hi_reg[0] <= 1'b0;
         if (cmd_op == cssi_pkg::OP_SEL_RB1) status_hi_reg[0] <= 1'b1;
      end
   end
   always_comb bank_reg = status_hi_reg[0];

   // Interrupt state
   wire ret_restore_2nd = (state_reg == cssi_pkg::ST_POP) && restore_reg;
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_reg <= 1'b0;
         tmr_en_reg <= 1'b0;
         in_irq_reg <= 1'b0;
         tmr_pend_reg <= 1'b0;
         tmr_ovf_reg <= 1'b0;
         cnt_mode_reg <= 1'b0;
         count_reg <= 8'h00;
         second_cyc_reg <= 1'b0;
         prev_tb_reg <= 1'b1;
         cond_sel_reg <= 8'h00;
         acc_reg <= 8'h00;
      end else begin
         prev_tb_reg <= TEST_INPUT_B;
         if (op_step2) second_cyc_reg <= ~second_cyc_reg;
         if (cmd_go && cmd_op == cssi_pkg::OP_EN_I) irq_en_reg <= 1'b1;
         if (cmd_go && cmd_op == cssi_pkg::OP_IRQ_DISABLE_OP) irq_en_reg <= 1'b0;
         if (cmd_go && cmd_op == cssi_pkg::OP_EN_TI) tmr_en_reg <= 1'b1;
         if (cmd_go && cmd_op == cssi_pkg::OP_DIS_TI) tmr_en_reg <= 1'b0;
         if (take_ext || take_tmr) in_irq_reg <= 1'b1;
         else if (ret_restore_2nd) in_irq_reg <= 1'b0;
         if (cnt_ovf || (cmd_go && cmd_tmr_edge)) tmr_pend_reg <= 1'b1;
         else if (take_tmr || (cmd_go && cmd_op == cssi_pkg::OP_DIS_TI)) tmr_pend_reg <= 1'b0;
         if (cnt_ovf) tmr_ovf_reg <= 1'b1;
         else if (bus_rd_phase && hit_stat) tmr_ovf_reg <= 1'b0;
         if (cmd_go && cmd_op == cssi_pkg::OP_STRT_CNT) cnt_mode_reg <= 1'b1;
         if (cmd_go && cmd_op == cssi_pkg::OP_STOP) cnt_mode_reg <= 1'b0;
         if (bus_wr && hit_stat) count_reg <= PWDATA[7:0];
         else if (cnt_mode_reg && tb_fall) count_reg <= count_reg + 8'h01;
         if (bus_wr && hit_cond) cond_sel_reg <= PWDATA[7:0];
         if (bus_wr && hit_cond) acc_reg <= PWDATA[15:8];
      end
   end

   // Read mux
   logic [31:0] rd_next;
   always_comb begin
      rd_next = 32'h0000_0000;
      if (hit_pc) rd_next = {20'h00000, pc_reg};
      else if (hit_status) rd_next = {24'h000000, status_word};
      else if (hit_stat) rd_next = {16'h0000, count_reg, 1'b0, state_reg != cssi_pkg::ST_IDLE,
         cnt_mode_reg, tmr_ovf_reg, tmr_pend_reg, tmr_en_reg, in_irq_reg, irq_en_reg};
      else if (hit_cond) rd_next = {15'h0000, cond_taken, acc_reg, cond_sel_reg};
      else if (hit_ram) rd_next = {24'h000000, ram_rd_a};
   end
   assign PRDATA = (bus_rd_phase && mapped) ? rd_next : 32'h0000_0000;

   assign PC_OUT = pc_reg;
   assign PROGRAM_STATUS = status_word;
   assign REG_BANK_SELECT = bank_reg;
   assign IRQ_ACTIVE = in_irq_reg;

   // Checks
   wire [11:0] pop_pc = {ram_rd_b[3:0], ram_rd_a};
   wire [3:0] pop_status = ram_rd_b[7:4];
   wire [4:0] push_lo_addr = 5'(`CSSI_STACK_BASE) + {1'b0, sp_reg, 1'b0};
   wire [4:0] push_hi_addr = 5'(`CSSI_STACK_BASE) + {1'b0, sp_reg, 1'b0} + 5'h01;

   // A push is two busy cycles: low byte, then high byte and the new counter
   sequence seq_push;
      state_reg == cssi_pkg::ST_PUSH_LO ##1 state_reg == cssi_pkg::ST_PUSH_HI;
   endsequence

   // Reset
   chk_reset_pc_zero: assert property (@(posedge CLOCK) $rose(rst_n) |-> pc_reg == 12'h000)
      else $error("pc not zero after reset");
   chk_reset_irq_off: assert property (@(posedge CLOCK) $rose(rst_n) |-> !irq_en_reg)
      else $error("interrupts enabled after reset");

   // Stack traffic
   chk_call_pushes: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (do_call || take_ext || take_tmr) |=> seq_push)
      else $error("call did not push");
   chk_push_lo_byte: assert property (@(posedge CLOCK) disable iff (!rst_n)
      state_reg == cssi_pkg::ST_PUSH_LO |-> ram_we && ram_waddr == push_lo_addr &&
      ram_wdata == pc_reg[7:0])
      else $error("stack low byte wrong");
   chk_push_hi_byte: assert property (@(posedge CLOCK) disable iff (!rst_n)
      state_reg == cssi_pkg::ST_PUSH_HI |-> ram_we && ram_waddr == push_hi_addr &&
      ram_wdata == {status_hi_reg, pc_reg[11:8]})
      else $error("stack high byte wrong");
   chk_push_inc_sp: assert property (@(posedge CLOCK) disable iff (!rst_n)
      state_reg == cssi_pkg::ST_PUSH_HI |=> sp_reg == $past(sp_reg) + 3'h1)
      else $error("stack pointer did not increment");
   chk_ret_dec_sp: assert property (@(posedge CLOCK) disable iff (!rst_n)
      do_ret |=> sp_reg == $past(sp_reg) - 3'h1 ##1 state_reg == cssi_pkg::ST_IDLE)
      else $error("return did not decrement pointer");
   chk_pop_loads_pc: assert property (@(posedge CLOCK) disable iff (!rst_n)
      state_reg == cssi_pkg::ST_POP |=> pc_reg == $past(pop_pc))
      else $error("return address wrong");
   chk_restore_status: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (state_reg == cssi_pkg::ST_POP && restore_reg) |=>
      status_hi_reg == $past(pop_status) && !in_irq_reg)
      else $error("restoring return wrong");
   chk_plain_ret_status: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (state_reg == cssi_pkg::ST_POP && !restore_reg) |=> status_hi_reg == $past(status_hi_reg))
      else $error("plain return changed status");

   // Interrupt entry: the vector lands once the push has finished
   chk_ext_vector: assert property (@(posedge CLOCK) disable iff (!rst_n)
      take_ext |=> seq_push ##1 pc_reg == `CSSI_VEC_EXT)
      else $error("external vector wrong");
   chk_tmr_vector: assert property (@(posedge CLOCK) disable iff (!rst_n)
      take_tmr |=> seq_push ##1 pc_reg == `CSSI_VEC_TMR)
      else $error("timer vector wrong");
   chk_ext_priority: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (sample_now && can_take && ext_req) |-> !take_tmr ##1 target_reg == `CSSI_VEC_EXT)
      else $error("timer beat external");
   chk_tmr_pend_held: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (tmr_pend_reg && !take_tmr && !(cmd_go && cmd_op == cssi_pkg::OP_DIS_TI)) |=> tmr_pend_reg)
      else $error("pending timer request lost");
   chk_ovf_pends: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (cnt_ovf && !(bus_wr && hit_stat)) |=> tmr_pend_reg && count_reg == 8'h00)
      else $error("overflow did not raise request");
   chk_two_cycle_first: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (op_step2 && !second_cyc_reg) |-> !take_ext && !take_tmr)
      else $error("sampled in first cycle");
   chk_single_level: assert property (@(posedge CLOCK) disable iff (!rst_n)
      in_irq_reg |-> !take_ext && !take_tmr)
      else $error("nested interrupt taken");

   // Status word
   chk_bit3_one: assert property (@(posedge CLOCK) disable iff (!rst_n)
      PROGRAM_STATUS[3] && PROGRAM_STATUS[2:0] == sp_reg)
      else $error("status layout wrong");
   chk_bank_select: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (cmd_go && cmd_op == cssi_pkg::OP_SEL_RB1 && state_reg == cssi_pkg::ST_IDLE) |=> REG_BANK_SELECT)
      else $error("bank one not selected");
endmodule // cssi_top

// ===== hdl/cssi_defines.svh
// Constants of the call stack, status word and interrupt entry block
`ifndef CSSI_DEFINES_SVH
`define CSSI_DEFINES_SVH
`define CSSI_PC_W 12
`define CSSI_PC_RESET 12'h000
`define CSSI_VEC_EXT 12'h003
`define CSSI_VEC_TMR 12'h007
`define CSSI_STACK_BASE 8'h08
`define CSSI_BANK1_BASE 8'h18
`define CSSI_STATUS_RESET 8'h08
`define CSSI_STATUS_ONE_BIT 3
`define CSSI_STATUS_BANK_BIT 4
`define CSSI_STATUS_FLAG_BIT 5
`define CSSI_STATUS_HALF_BIT 6
`define CSSI_STATUS_CARRY_BIT 7
`define CSSI_CNT_TOP 8'hFF
`define CSSI_ADDR_PC 12'h000
`define CSSI_ADDR_STATUS 12'h004
`define CSSI_ADDR_CMD 12'h008
`define CSSI_ADDR_STAT 12'h00C
`define CSSI_ADDR_COND 12'h010
`define CSSI_ADDR_RAM 12'h100
`endif

// ===== hdl/cssi_pkg.sv
// Types of the call stack, status word and interrupt entry block
package cssi_pkg;
   typedef enum logic [3:0] {
      OP_NONE = 4'h0, OP_CALL = 4'h1, OP_RETURN_PLAIN = 4'h2, OP_RETURN_RESTORE = 4'h3,
      OP_EN_I = 4'h4, OP_IRQ_DISABLE_OP = 4'h5, OP_EN_TI = 4'h6, OP_DIS_TI = 4'h7,
      OP_CPL_FLAG = 4'h8, OP_CLR_FLAG = 4'h9, OP_SEL_RB0 = 4'hA, OP_SEL_RB1 = 4'hB,
      OP_STRT_CNT = 4'hC, OP_STOP = 4'hD, OP_STEP = 4'hE, OP_STEP2 = 4'hF
   } cssi_op_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001, ST_PUSH_LO = 4'b0010, ST_PUSH_HI = 4'b0100, ST_POP = 4'b1000
   } cssi_state_t;
endpackage

// ===== hdl/cssi_stack_ram.sv
// Data RAM holding working registers and the return stack
`timescale 1ns/1ns
module cssi_stack_ram (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [4:0] waddr,
   input wire logic [7:0] wdata,
   // Read ports
   input wire logic [4:0] raddr_a,
   output logic [7:0] rdata_a,
   input wire logic [4:0] raddr_b,
   output logic [7:0] rdata_b
);
   logic [7:0] mem_reg [0:31];
   always_ff @(posedge clk) begin
      if (we) begin
         mem_reg[waddr] <= wdata;
      end
   end
   assign rdata_a = mem_reg[raddr_a];
   assign rdata_b = mem_reg[raddr_b];
endmodule // cssi_stack_ram

// ===== hdl/cssi_cond.sv
// Conditional branch test selector
`timescale 1ns/1ns
module cssi_cond (
   // Condition select and operands
   input wire logic [3:0] sel,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] acc,
   input wire logic carry,
   input wire logic flag_a,
   input wire logic flag_b,
   input wire logic tmr_ovf,
   input wire logic test_a,
   input wire logic test_b,
   input wire logic int_n,
   // Result
   output logic taken
);
   always_comb begin
      case (sel)
         4'h0: taken = (acc == 8'h00);
         4'h1: taken = (acc != 8'h00);
         4'h2: taken = acc[bit_sel];
         4'h3: taken = ~carry;
         4'h4: taken = carry;
         4'h5: taken = flag_a;
         4'h6: taken = flag_b;
         4'h7: taken = tmr_ovf;
         4'h8: taken = ~test_a;
         4'h9: taken = test_a;
         4'hA: taken = ~test_b;
         4'hB: taken = test_b;
         4'hC: taken = ~int_n;
         default: taken = 1'b0;
      endcase
   end
endmodule // cssi_cond

// ===== tb/cssi_irq_src.sv
// Open-drain interrupt sources sharing one pulled-up request line
`timescale 1ns/1ns
module cssi_irq_src #(
   parameter int NSRC = 2,
   parameter int HOLD = 9
) (
   // Clock
   input wire logic clk,
   // Requests asked for by the bench
   input wire logic [NSRC-1:0] want,
   // Shared line
   output logic int_n
);
   logic [NSRC-1:0] pull = '0;
   int held [NSRC] = '{default: 0};
   // A source never lets go early, however short the request was
   always @(posedge clk) begin
      for (int i = 0; i < NSRC; i++) begin
         if (want[i]) begin
            pull[i] <= 1'b1;
         end else if (held[i] >= HOLD) begin
            pull[i] <= 1'b0;
         end
         held[i] <= pull[i] ? held[i] + 1 : 0;
      end
   end
   // Released line floats up to the pull-up level
   assign int_n = ~|pull;
endmodule // cssi_irq_src

// ===== tb/call_stack_status_interrupt_test.sv
// Self-checking bench of the call stack, status word and interrupt block
`timescale 1ns/1ns
`include "cssi_defines.svh"
module call_stack_status_interrupt_test;
   logic CLOCK = 1'b0;
   logic RESET_N = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0;
   logic TEST_INPUT_A = 1'b1;
   logic TEST_INPUT_B = 1'b1;
   logic [1:0] want = 2'h0;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic INT_N;
   logic [11:0] PC_OUT;
   logic [7:0] PROGRAM_STATUS;
   logic REG_BANK_SELECT;
   logic IRQ_ACTIVE;
   logic [31:0] q;
   logic [31:0] r;
   logic e;
   logic lvl;
   logic [11:0] epc;
   logic [7:0] estat;
   logic [11:0] spc [8];
   logic [3:0] shi [8];
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   int seed = 67;
   cssi_top uut (
      .CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .INT_N(INT_N), .TEST_INPUT_A(TEST_INPUT_A), .TEST_INPUT_B(TEST_INPUT_B),
      .PC_OUT(PC_OUT), .PROGRAM_STATUS(PROGRAM_STATUS), .REG_BANK_SELECT(REG_BANK_SELECT),
      .IRQ_ACTIVE(IRQ_ACTIVE)
   );
   cssi_irq_src #(.NSRC(2), .HOLD(9)) src (.clk(CLOCK), .want(want), .int_n(INT_N));
   always #50 CLOCK = ~CLOCK;
   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         fails = fails + 1;
         conclude();
      end
   end
   task automatic conclude();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
      checked = checked + 1;
      if (g !== x) begin
         fails = fails + 1;
         $display("wrong value %s expected %h seen %h", what, x, g);
      end
   endtask
   // Request held until pready is seen high; released at that same edge, then one idle edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      @(posedge CLOCK);
      while (PREADY !== 1'b1) @(posedge CLOCK);
      q = PRDATA;
      e = PSLVERR;
      lvl = INT_N;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLOCK);
   endtask
   // Waits past the sequencer's busy cycles before the next request
   task automatic op(input cssi_pkg::cssi_op_t o, input logic [23:0] x);
      apb(1'b1, `CSSI_ADDR_CMD, {4'h0, x, o});
      repeat (3) @(posedge CLOCK);
   endtask
   task automatic wstat(input logic [7:0] v);
      apb(1'b1, `CSSI_ADDR_STATUS, {24'h0, v});
      estat = v | 8'h08;
   endtask
   task automatic st(input string what);
      apb(1'b0, `CSSI_ADDR_PC, 32'h0);
      chk({what, " pc"}, {20'h0, epc}, {20'h0, q[11:0]});
      apb(1'b0, `CSSI_ADDR_STATUS, 32'h0);
      chk({what, " status"}, {24'h0, estat}, {24'h0, q[7:0]});
      chk({what, " status pins"}, {24'h0, estat}, {24'h0, PROGRAM_STATUS});
   endtask
   task automatic ent(input logic [2:0] s);
      apb(1'b0, `CSSI_ADDR_RAM + 12'h020 + {6'h0, s, 3'h0}, 32'h0);
      chk("stack even byte", {24'h0, spc[s][7:0]}, {24'h0, q[7:0]});
      apb(1'b0, `CSSI_ADDR_RAM + 12'h024 + {6'h0, s, 3'h0}, 32'h0);
      chk("stack odd byte", {24'h0, shi[s], spc[s][11:8]}, {24'h0, q[7:0]});
   endtask
   task automatic push(input logic [11:0] t);
      spc[estat[2:0]] = epc;
      shi[estat[2:0]] = estat[7:4];
      estat[2:0] = estat[2:0] + 3'h1;
      epc = t;
   endtask
   task automatic pop(input logic rs);
      op(rs ? cssi_pkg::OP_RETURN_RESTORE : cssi_pkg::OP_RETURN_PLAIN, 24'h0);
      estat[2:0] = estat[2:0] - 3'h1;
      epc = spc[estat[2:0]];
      if (rs) estat[7:4] = shi[estat[2:0]];
   endtask
   task automatic stp(input logic [11:0] v, input logic tk);
      op(cssi_pkg::OP_STEP, 24'h0);
      epc = epc + 12'h001;
      if (tk) push(v);
   endtask
   task automatic irq(input logic x);
      chk("in service", {31'h0, x}, {31'h0, IRQ_ACTIVE});
   endtask
   function automatic logic cexp(input logic [3:0] s, input logic [7:0] a,
                                 input logic [2:0] b, input logic fb, input logic n);
      case (s)
         4'h0: return a == 8'h00;
         4'h1: return a != 8'h00;
         4'h2: return a[b];
         4'h3: return !estat[7];
         4'h4: return estat[7];
         4'h5: return estat[5];
         4'h6: return fb;
         4'h7: return 1'b0;
         4'h8: return !TEST_INPUT_A;
         4'h9: return TEST_INPUT_A;
         4'hA: return !TEST_INPUT_B;
         4'hB: return TEST_INPUT_B;
         default: return !n;
      endcase
   endfunction
   initial begin
      repeat (6) @(posedge CLOCK);
      RESET_N <= 1'b1;
      repeat (3) @(posedge CLOCK);
      epc = 12'h000;
      estat = 8'h08;
      st("reset");
      apb(1'b0, `CSSI_ADDR_STAT, 32'h0);
      chk("irq enable", 32'h0, {31'h0, q[0]});
      chk("mapped error", 32'h0, {31'h0, e});
      apb(1'b1, `CSSI_ADDR_PC, 32'hFFFFFFFF);
      epc = 12'hFFF;
      want[0] <= 1'b1;
      stp(12'h000, 1'b0);
      st("masked step");
      irq(1'b0);
      want[0] <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         wstat(r[7:0]);
         st("status write");
         chk("bank pin", {31'h0, r[4]}, {31'h0, REG_BANK_SELECT});
      end
      op(cssi_pkg::OP_SEL_RB1, 24'h0);
      estat[4] = 1'b1;
      st("bank one");
      op(cssi_pkg::OP_SEL_RB0, 24'h0);
      estat[4] = 1'b0;
      op(cssi_pkg::OP_CPL_FLAG, 24'h0);
      estat[5] = ~estat[5];
      st("flag toggle");
      op(cssi_pkg::OP_CLR_FLAG, 24'h0);
      estat[5] = 1'b0;
      op(cssi_pkg::OP_NONE, 24'h000007);
      estat[7:6] = 2'b10;
      st("flag clear carry set");
      op(cssi_pkg::OP_NONE, 24'h00000C);
      estat[6] = 1'b1;
      st("half carry");
      // Reading the stat register clears the overflow flag, so it is known low
      apb(1'b0, `CSSI_ADDR_STAT, 32'h0);
      for (int i = 0; i < 26; i++) begin
         r = $random(seed);
         TEST_INPUT_A <= r[16];
         TEST_INPUT_B <= r[17];
         want[1] <= r[18];
         wstat(r[31:24]);
         apb(1'b1, `CSSI_ADDR_COND, {16'h0, r[15:4], 4'(i % 13)});
         apb(1'b0, `CSSI_ADDR_COND, 32'h0);
         chk("branch", {31'h0, cexp(4'(i % 13), r[15:8], r[6:4], r[7], lvl)},
             {31'h0, q[16]});
      end
      want[1] <= 1'b0;
      TEST_INPUT_B <= 1'b1;
      wstat(8'h00);
      r = $random(seed);
      apb(1'b1, `CSSI_ADDR_PC, {20'h0, r[11:0]});
      epc = r[11:0];
      for (int i = 0; i < 9; i++) begin
         r = $random(seed);
         wstat({r[31:28], 1'b0, estat[2:0]});
         op(cssi_pkg::OP_CALL, {r[11:0], 12'h000});
         push(r[11:0]);
         st("call");
         ent(estat[2:0] - 3'h1);
      end
      for (int i = 0; i < 9; i++) begin
         pop(i[0]);
         st("return");
      end
      wstat(8'h00);
      apb(1'b1, `CSSI_ADDR_PC, 32'h00000100);
      epc = 12'h100;
      op(cssi_pkg::OP_EN_I, 24'h0);
      op(cssi_pkg::OP_EN_TI, 24'h0);
      want[0] <= 1'b1;
      op(cssi_pkg::OP_NONE, 24'h000010);
      stp(`CSSI_VEC_EXT, 1'b1);
      st("external first");
      irq(1'b1);
      stp(12'h000, 1'b0);
      st("no nesting");
      apb(1'b0, `CSSI_ADDR_STAT, 32'h0);
      chk("timer pending", 32'h1, {31'h0, q[3]});
      want[0] <= 1'b0;
      repeat (30) if (INT_N !== 1'b1) @(posedge CLOCK);
      pop(1'b1);
      st("restoring return");
      irq(1'b0);
      stp(`CSSI_VEC_TMR, 1'b1);
      st("timer after");
      apb(1'b0, `CSSI_ADDR_STAT, 32'h0);
      chk("timer served", 32'h0, {31'h0, q[3]});
      pop(1'b1);
      // The count preset sits in the low byte of a stat register write
      apb(1'b1, `CSSI_ADDR_STAT, {24'h0, `CSSI_CNT_TOP});
      op(cssi_pkg::OP_STRT_CNT, 24'h0);
      TEST_INPUT_B <= 1'b0;
      repeat (4) @(posedge CLOCK);
      stp(`CSSI_VEC_TMR, 1'b1);
      st("event vector");
      pop(1'b1);
      want[0] <= 1'b1;
      op(cssi_pkg::OP_STEP2, 24'h0);
      irq(1'b0);
      op(cssi_pkg::OP_STEP2, 24'h0);
      irq(1'b1);
      chk("two cycle vector", {20'h0, `CSSI_VEC_EXT}, {20'h0, PC_OUT});
      apb(1'b0, 12'h020, 32'h0);
      chk("slave error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      conclude();
   end
endmodule // call_stack_status_interrupt_test
